// ===== core/stc_cmd_handler.sv
// custom command handler: password and log mode commands with coded replies
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stc_cmd_handler (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// decoded custom command from the baseband
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_code,
	input wire logic [7:0] i_cmd_level,
	input wire logic [31:0] i_cmd_arg,
	input wire logic [15:0] i_cmd_handle,
	// open area password from the baseband
	input wire logic i_open_valid,
	input wire logic [1:0] i_open_level,
	input wire logic [31:0] i_open_pw,
	input wire logic i_field_lost,
	// tag state
	input wire logic i_passive,
	input wire logic i_batt_present,
	input wire logic i_supply_low,
	input wire logic i_rtc_active,
	input wire logic i_ee_busy,
	input wire logic i_batt_low_pin,
	input wire logic i_meas_tick,
	// reply frame, msb first
	output logic o_reply_valid,
	output logic [41:0] o_reply_frame,
	output logic [5:0] o_reply_len,
	// eeprom write request
	output logic o_ee_wr,
	output logic [15:0] o_ee_addr,
	output logic [31:0] o_ee_data,
	// logging control
	output logic [23:0] o_log_mode,
	output logic [15:0] o_log_period_s,
	output logic o_meas_store,
	output logic o_batt_store,
	output logic o_low_batt
);
	// crc-16 over the low len bits of d, msb first, result complemented
	function automatic logic [15:0] crc16(input logic [24:0] d, input int len);
		logic [15:0] c;
		logic fb;
		c = stc_pkg::CRC_INIT;
		for (int i = 24; i >= 0; i--) begin
			if (i < len) begin
				fb = c[15] ^ d[i];
				c = {c[14:0], 1'b0} ^ (fb ? stc_pkg::CRC_POLY : 16'h0000);
			end
		end
		return ~c;
	endfunction

	// area index from level code
	function automatic logic [1:0] lvl_idx(input logic [1:0] lvl);
		return 2'(lvl - 2'h1);
	endfunction

	logic [31:0] pw_store_r [3];
	logic [31:0] pw_open_r [3];
	logic [3:0] locks_r;
	logic [31:0] addr_cfg_r;
	logic [23:0] log_mode_r;
	logic low_batt_r;
	logic [7:0] last_err_r;
	logic last_ok_r;
	logic batt_sync1_r;
	logic batt_sync2_r;
	logic reply_valid_r;
	logic [41:0] reply_frame_r;
	logic [5:0] reply_len_r;
	logic ee_wr_r;
	logic [15:0] ee_addr_r;
	logic [31:0] ee_data_r;
	logic meas_store_r;
	logic batt_store_r;
	logic [2:0] prot;
	logic [2:0] area_open;
	logic [1:0] lvl;
	logic [1:0] idx;
	logic err;
	logic [7:0] err_code;
	logic wr_ok;
	logic [15:0] wr_addr;
	logic batt_check;
	logic apb_wr;
	logic apb_rd;
	logic addr_hit;

	// protection follows the stored password; open means unprotected or opening copy matches
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			prot[k] = pw_store_r[k] != 32'h0000_0000;
			area_open[k] = !prot[k] || (pw_open_r[k] == pw_store_r[k]);
		end
	end

	// comparator level comes from the analog side, so synchronise it
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			batt_sync1_r <= 1'b0;
			batt_sync2_r <= 1'b0;
		end else if (i_clk_en) begin
			batt_sync1_r <= i_batt_low_pin;
			batt_sync2_r <= batt_sync1_r;
		end
	end

	// command check, highest priority first; busy beats all but an unknown code since nothing can run
	always_comb begin
		lvl = i_cmd_level[1:0];
		idx = lvl_idx(lvl);
		err = 1'b1;
		err_code = stc_pkg::ERR_OTHER;
		wr_addr = (i_cmd_code == stc_pkg::CMD_SET_PW) ?
			16'(addr_cfg_r[15:0] + {13'h0000, idx, 1'b0}) : addr_cfg_r[31:16];
		if (i_cmd_code != stc_pkg::CMD_SET_PW && i_cmd_code != stc_pkg::CMD_SET_LOG) begin
			err_code = stc_pkg::ERR_OTHER;
		end else if (i_ee_busy) begin
			err_code = stc_pkg::ERR_EE_BUSY;
		end else if (i_cmd_code == stc_pkg::CMD_SET_LOG && i_rtc_active) begin
			err_code = stc_pkg::ERR_NOT_ALLOWED;
		end else if (i_cmd_code == stc_pkg::CMD_SET_PW && lvl == stc_pkg::LVL_NONE) begin
			err_code = stc_pkg::ERR_OTHER;
		end else if (i_cmd_code == stc_pkg::CMD_SET_PW && locks_r[idx]) begin
			err_code = stc_pkg::ERR_LOCKED;
		end else if (i_cmd_code == stc_pkg::CMD_SET_LOG && locks_r[3]) begin
			err_code = stc_pkg::ERR_LOCKED;
		end else if (i_cmd_code == stc_pkg::CMD_SET_PW && !area_open[0] &&
			(lvl == stc_pkg::LVL_SYS || !area_open[idx])) begin
			err_code = stc_pkg::ERR_PASSWORD;
		end else if (i_cmd_code == stc_pkg::CMD_SET_LOG && !area_open[0]) begin
			err_code = stc_pkg::ERR_PASSWORD;
		end else if (wr_addr >= stc_pkg::EE_WORDS - 16'h0001) begin
			err_code = stc_pkg::ERR_OVERRUN;
		end else if (i_cmd_code == stc_pkg::CMD_SET_LOG && i_cmd_arg[stc_pkg::LM_BATT] &&
			i_passive && !i_batt_present) begin
			err_code = stc_pkg::ERR_BATT_MEAS;
		end else if (i_passive && i_supply_low) begin
			err_code = stc_pkg::ERR_POWER;
		end else begin
			err = 1'b0;
		end
		wr_ok = i_cmd_valid && !err;
	end

	// reply frame built and registered one cycle after the command
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reply_valid_r <= 1'b0;
			reply_frame_r <= 42'h000_0000_0000;
			reply_len_r <= 6'h00;
		end else if (i_clk_en) begin
			reply_valid_r <= i_cmd_valid;
			if (i_cmd_valid && err) begin
				reply_len_r <= stc_pkg::LEN_ERR;
				reply_frame_r <= {1'b1, err_code, i_cmd_handle,
					crc16({1'b1, err_code, i_cmd_handle}, 25), 1'b1};
			end else if (i_cmd_valid) begin
				reply_len_r <= stc_pkg::LEN_OK;
				reply_frame_r <= {1'b0, i_cmd_handle,
					crc16({8'h00, 1'b0, i_cmd_handle}, 17), 1'b1, 8'h00};
			end
		end
	end

	// eeprom write carries the new password or log mode word
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ee_wr_r <= 1'b0;
			ee_addr_r <= 16'h0000;
			ee_data_r <= 32'h0000_0000;
		end else if (i_clk_en) begin
			ee_wr_r <= wr_ok;
			if (wr_ok) begin
				ee_addr_r <= wr_addr;
				ee_data_r <= (i_cmd_code == stc_pkg::CMD_SET_PW) ? i_cmd_arg :
					{8'h00, i_cmd_arg[23:1], 1'b0};
			end
		end
	end

	// stored passwords mirror; apb may preload them at production
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < 3; k++) begin
				pw_store_r[k] <= 32'h0000_0000;
			end
		end else if (i_clk_en) begin
			if (wr_ok && i_cmd_code == stc_pkg::CMD_SET_PW) begin
				pw_store_r[idx] <= i_cmd_arg;
			end else if (apb_wr && i_paddr == stc_pkg::OFS_PW_SYS) begin
				pw_store_r[0] <= i_pwdata;
			end else if (apb_wr && i_paddr == stc_pkg::OFS_PW_APP) begin
				pw_store_r[1] <= i_pwdata;
			end else if (apb_wr && i_paddr == stc_pkg::OFS_PW_MEAS) begin
				pw_store_r[2] <= i_pwdata;
			end
		end
	end

	// opening passwords are volatile: field loss wipes them
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < 3; k++) begin
				pw_open_r[k] <= 32'h0000_0000;
			end
		end else if (i_clk_en) begin
			if (i_field_lost) begin
				for (int k = 0; k < 3; k++) begin
					pw_open_r[k] <= 32'h0000_0000;
				end
			end else if (i_open_valid && i_open_level != stc_pkg::LVL_NONE) begin
				pw_open_r[lvl_idx(i_open_level)] <= i_open_pw;
			end
		end
	end

	// log mode register; the split is read by the logging engine
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			log_mode_r <= 24'h00_0000;
		end else if (i_clk_en && wr_ok && i_cmd_code == stc_pkg::CMD_SET_LOG) begin
			log_mode_r <= {i_cmd_arg[23:1], 1'b0};
		end
	end

	// battery check after an accepted log mode command and on each measurement tick
	assign batt_check = (wr_ok && i_cmd_code == stc_pkg::CMD_SET_LOG) || i_meas_tick;

	// low flag: set beats the software clear
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_batt_r <= 1'b0;
		end else if (i_clk_en) begin
			if (batt_check && batt_sync2_r) begin
				low_batt_r <= 1'b1;
			end else if (apb_wr && i_paddr == stc_pkg::OFS_STATUS &&
				i_pwdata[stc_pkg::STAT_LOWBAT]) begin
				low_batt_r <= 1'b0;
			end
		end
	end

	// store strobes gated by the check made in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meas_store_r <= 1'b0;
			batt_store_r <= 1'b0;
		end else if (i_clk_en) begin
			meas_store_r <= i_meas_tick && !batt_sync2_r && !low_batt_r;
			batt_store_r <= i_meas_tick && !batt_sync2_r && !low_batt_r &&
				log_mode_r[stc_pkg::LM_BATT];
		end
	end

	// apb: zero wait states, unmapped offsets flag an error
	assign apb_wr = i_psel && i_penable && i_pwrite && addr_hit && i_clk_en;
	assign apb_rd = i_psel && !i_pwrite;
	assign o_pready = 1'b1;
	always_comb begin
		addr_hit = i_paddr[1:0] == 2'h0 && i_paddr <= stc_pkg::OFS_LAST;
		o_pslverr = i_psel && i_penable && !addr_hit;
	end

	// software locks and the eeprom placement of the words written
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			locks_r <= stc_pkg::RST_LOCKS;
			addr_cfg_r <= stc_pkg::RST_ADDR;
		end else if (apb_wr) begin
			if (i_paddr == stc_pkg::OFS_CTRL) begin
				locks_r <= i_pwdata[3:0];
			end
			if (i_paddr == stc_pkg::OFS_ADDR) begin
				addr_cfg_r <= i_pwdata;
			end
		end
	end

	// last outcome kept for software
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			last_err_r <= 8'h00;
			last_ok_r <= 1'b0;
		end else if (i_clk_en && i_cmd_valid) begin
			last_err_r <= err ? err_code : 8'h00;
			last_ok_r <= !err;
		end
	end

	// read data from flip-flops, sampled in the setup cycle
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_clk_en && apb_rd && !i_penable) begin
			unique case (i_paddr)
				stc_pkg::OFS_CTRL: o_prdata <= {28'h000_0000, locks_r};
				stc_pkg::OFS_STATUS: o_prdata <= {24'h00_0000, area_open, prot, 1'b0,
					low_batt_r};
				stc_pkg::OFS_LOGMODE: o_prdata <= {8'h00, log_mode_r};
				stc_pkg::OFS_PW_SYS: o_prdata <= pw_store_r[0];
				stc_pkg::OFS_PW_APP: o_prdata <= pw_store_r[1];
				stc_pkg::OFS_PW_MEAS: o_prdata <= pw_store_r[2];
				stc_pkg::OFS_ADDR: o_prdata <= addr_cfg_r;
				stc_pkg::OFS_LAST: o_prdata <= {23'h00_0000, last_ok_r, last_err_r};
				default: o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// outputs
	assign o_reply_valid = reply_valid_r;
	assign o_reply_frame = reply_frame_r;
	assign o_reply_len = reply_len_r;
	assign o_ee_wr = ee_wr_r;
	assign o_ee_addr = ee_addr_r;
	assign o_ee_data = ee_data_r;
	assign o_log_mode = log_mode_r;
	assign o_log_period_s = {1'b0, log_mode_r[stc_pkg::LM_IVL_HI:stc_pkg::LM_IVL_LO]} +
		16'h0001;
	assign o_meas_store = meas_store_r;
	assign o_batt_store = batt_store_r;
	assign o_low_batt = low_batt_r;

	// checks
	sequence s_cmd;
		i_cmd_valid && i_clk_en;
	endsequence
	sequence s_err_reply;
		o_reply_valid && o_reply_frame[41] && o_reply_len == stc_pkg::LEN_ERR;
	endsequence

	property p_reply;
		@(posedge i_ref_clk) disable iff (!i_reset_n) s_cmd |=> o_reply_valid;
	endproperty
	a_reply: assert property (p_reply) else $error("command without reply");

	property p_err_frame;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 err |=> s_err_reply ##0 o_reply_frame[0];
	endproperty
	a_err_frame: assert property (p_err_frame) else $error("bad error frame");

	property p_ok_frame;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 !err |=> o_reply_len == stc_pkg::LEN_OK && !o_reply_frame[41]
			&& o_reply_frame[8] && o_ee_wr;
	endproperty
	a_ok_frame: assert property (p_ok_frame) else $error("bad success frame");

	property p_unknown;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 (i_cmd_code != stc_pkg::CMD_SET_PW && i_cmd_code != stc_pkg::CMD_SET_LOG)
			|=> s_err_reply ##0 o_reply_frame[40:33] == stc_pkg::ERR_OTHER;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown code not 00");

	property p_busy;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 (i_ee_busy && (i_cmd_code == stc_pkg::CMD_SET_PW ||
			i_cmd_code == stc_pkg::CMD_SET_LOG)) |=> s_err_reply ##0
			o_reply_frame[40:33] == stc_pkg::ERR_EE_BUSY;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not reported");

	property p_rtc;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 (i_cmd_code == stc_pkg::CMD_SET_LOG && i_rtc_active && !i_ee_busy)
			|=> !o_ee_wr ##0 o_reply_frame[40:33] == stc_pkg::ERR_NOT_ALLOWED;
	endproperty
	a_rtc: assert property (p_rtc) else $error("log change in active state");

	property p_level0;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 (i_cmd_code == stc_pkg::CMD_SET_PW && i_cmd_level[1:0] == 2'h0)
			|=> !o_ee_wr && o_reply_frame[41];
	endproperty
	a_level0: assert property (p_level0) else $error("level 00 accepted");

	property p_sys_closed;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			s_cmd ##0 (i_cmd_code == stc_pkg::CMD_SET_PW && i_cmd_level[1:0] ==
			stc_pkg::LVL_SYS && !area_open[0]) |=> !o_ee_wr;
	endproperty
	a_sys_closed: assert property (p_sys_closed) else $error("system pw changed");

	property p_lowbat;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			i_clk_en && i_meas_tick && batt_sync2_r |=> !o_meas_store ##0 o_low_batt;
	endproperty
	a_lowbat: assert property (p_lowbat) else $error("stored on low battery");

	property p_field_lost;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
			i_clk_en && i_field_lost |=> pw_open_r[0] == 32'h0000_0000 &&
			pw_open_r[2] == 32'h0000_0000;
	endproperty
	a_field_lost: assert property (p_field_lost) else $error("open pw kept");
endmodule
`default_nettype wire

// ===== core/stc_pkg.sv
// constants for the tag custom command handler
package stc_pkg;
	// command framing
	localparam logic [7:0] CMD_SET_PW = 8'ha0;
	localparam logic [7:0] CMD_SET_LOG = 8'ha1;
	// error codes
	localparam logic [7:0] ERR_OTHER = 8'h00;
	localparam logic [7:0] ERR_OVERRUN = 8'h03;
	localparam logic [7:0] ERR_LOCKED = 8'h04;
	localparam logic [7:0] ERR_POWER = 8'h0b;
	localparam logic [7:0] ERR_PASSWORD = 8'ha0;
	localparam logic [7:0] ERR_BATT_MEAS = 8'ha2;
	localparam logic [7:0] ERR_NOT_ALLOWED = 8'ha3;
	localparam logic [7:0] ERR_EE_BUSY = 8'ha6;
	// password levels (low two bits of the level byte)
	localparam logic [1:0] LVL_NONE = 2'h0;
	localparam logic [1:0] LVL_SYS = 2'h1;
	localparam logic [1:0] LVL_APP = 2'h2;
	localparam logic [1:0] LVL_MEAS = 2'h3;
	// log mode field positions
	localparam int LM_FORM_HI = 23;
	localparam int LM_FORM_LO = 21;
	localparam int LM_STORE = 20;
	localparam int LM_EXT1 = 19;
	localparam int LM_EXT2 = 18;
	localparam int LM_TEMP = 17;
	localparam int LM_BATT = 16;
	localparam int LM_IVL_HI = 15;
	localparam int LM_IVL_LO = 1;
	// reply framing
	localparam int FRAME_W = 42;
	localparam logic [5:0] LEN_ERR = 6'h2a;
	localparam logic [5:0] LEN_OK = 6'h22;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	// eeprom size in 16-bit words, for address checks
	localparam logic [15:0] EE_WORDS = 16'h0240;
	// apb register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LOGMODE = 8'h08;
	localparam logic [7:0] OFS_PW_SYS = 8'h0c;
	localparam logic [7:0] OFS_PW_APP = 8'h10;
	localparam logic [7:0] OFS_PW_MEAS = 8'h14;
	localparam logic [7:0] OFS_ADDR = 8'h18;
	localparam logic [7:0] OFS_LAST = 8'h1c;
	// reset values and the status low battery bit
	localparam logic [31:0] RST_ADDR = 32'h0010_0008;
	localparam logic [3:0] RST_LOCKS = 4'h0;
	localparam int STAT_LOWBAT = 0;
endpackage

// ===== testbench/stc_interrogator.sv
// interrogator model: issues custom commands and area opening passwords
`timescale 1ns/1ps
`default_nettype none
module stc_interrogator (
	input wire logic i_ref_clk,
	output logic o_cmd_valid,
	output logic [7:0] o_cmd_code,
	output logic [7:0] o_cmd_level,
	output logic [31:0] o_cmd_arg,
	output logic [15:0] o_cmd_handle,
	output logic o_open_valid,
	output logic [1:0] o_open_level,
	output logic [31:0] o_open_pw
);
	// quiet link before the first frame
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code = 8'h00;
		o_cmd_level = 8'h00;
		o_cmd_arg = 32'h0;
		o_cmd_handle = 16'h0;
		o_open_valid = 1'b0;
		o_open_level = 2'h0;
		o_open_pw = 32'h0;
	end
	// prefix and crc are stripped by the baseband; fields are scrambled after the pulse
	task automatic send(input logic [7:0] code, lvl, input logic [31:0] arg, input logic [15:0] h);
		@(posedge i_ref_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_code <= code;
		o_cmd_level <= lvl;
		o_cmd_arg <= arg;
		o_cmd_handle <= h;
		@(posedge i_ref_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_code <= ~code;
		o_cmd_level <= ~lvl;
		o_cmd_arg <= ~arg;
		o_cmd_handle <= ~h;
	endtask
	// opening password for one area, one cycle long
	task automatic open_area(input logic [1:0] lvl, input logic [31:0] pw);
		@(posedge i_ref_clk);
		o_open_valid <= 1'b1;
		o_open_level <= lvl;
		o_open_pw <= pw;
		@(posedge i_ref_clk);
		o_open_valid <= 1'b0;
		o_open_level <= ~lvl;
		o_open_pw <= ~pw;
	endtask
endmodule
`default_nettype wire

// ===== testbench/stc_cmd_handler_test.sv
// self-checking bench for the custom command handler
`timescale 1ns/1ps
`default_nettype none
module stc_cmd_handler_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rd_err;
	logic cv, ov, fl = 1'b0;
	logic [7:0] cc, cl;
	logic [31:0] ca, op, pw, m;
	logic [15:0] ch;
	logic [1:0] ol;
	logic passive = 1'b0, batt = 1'b0, sup_low = 1'b0, rtc = 1'b0, busy = 1'b0;
	logic bpin = 1'b0, tick = 1'b0, ce = 1'b1;
	logic rv, ewr, mst, bst, lowb;
	logic [41:0] frame;
	logic [5:0] len;
	logic [15:0] eaddr, period;
	logic [31:0] edata;
	logic [23:0] lmode;
	logic [31:0] seed = 32'd72301;
	int n_mismatch = 0;
	int comparisons = 0;
	bit seen, seen_b;

	always #5 clk = ~clk;

	stc_interrogator u_stc_interrogator (.i_ref_clk(clk), .o_cmd_valid(cv), .o_cmd_code(cc),
		.o_cmd_level(cl), .o_cmd_arg(ca), .o_cmd_handle(ch), .o_open_valid(ov),
		.o_open_level(ol), .o_open_pw(op));

	stc_cmd_handler u_stc_cmd_handler (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_level(cl), .i_cmd_arg(ca),
		.i_cmd_handle(ch), .i_open_valid(ov), .i_open_level(ol), .i_open_pw(op),
		.i_field_lost(fl), .i_passive(passive), .i_batt_present(batt),
		.i_supply_low(sup_low), .i_rtc_active(rtc), .i_ee_busy(busy),
		.i_batt_low_pin(bpin), .i_meas_tick(tick), .o_reply_valid(rv),
		.o_reply_frame(frame), .o_reply_len(len), .o_ee_wr(ewr), .o_ee_addr(eaddr),
		.o_ee_data(edata), .o_log_mode(lmode), .o_log_period_s(period),
		.o_meas_store(mst), .o_batt_store(bst), .o_low_batt(lowb));

	// galois shift register for repeatable random values
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
	endfunction

	// reply crc over header, error code if present, and handle, msb first
	function automatic logic [15:0] crc16(input logic [24:0] d, input int n);
		logic [15:0] c;
		c = stc_pkg::CRC_INIT;
		for (int i = n - 1; i >= 0; i--) begin
			c = (c << 1) ^ ((c[15] ^ d[i]) ? stc_pkg::CRC_POLY : 16'h0);
		end
		return ~c;
	endfunction

	task automatic cmp_frame(input string what, input logic [41:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_val(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// apb transfer: setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one command and its reply, expected frame built here
	task automatic cmd(input logic [7:0] code, lvl, input logic [31:0] arg,
		input logic ok, input logic [7:0] ec);
		logic [15:0] h;
		logic [41:0] f;
		seed = lfsr(seed);
		h = seed[15:0];
		u_stc_interrogator.send(code, lvl, arg, h);
		#1;
		if (ok) f = {1'b0, h, crc16({8'h00, 1'b0, h}, 17), 1'b1, 8'h00};
		else f = {1'b1, ec, h, crc16({1'b1, ec, h}, 25), 1'b1};
		cmp_val("reply_valid", 32'h1, {31'h0, rv});
		cmp_frame("reply_frame", f, frame);
		cmp_val("reply_len", {26'h0, ok ? stc_pkg::LEN_OK : stc_pkg::LEN_ERR}, {26'h0, len});
		cmp_val("ee_wr", {31'h0, ok}, {31'h0, ewr});
	endtask

	// catch one-cycle store pulses, starting with the cycle just launched
	task automatic watch(input int n, output bit got, output bit got_b);
		got = 0;
		got_b = 0;
		repeat (n) begin
			#1;
			if (mst === 1'b1) got = 1;
			if (bst === 1'b1) got_b = 1;
			@(posedge clk);
		end
		#1;
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog well beyond the length of the sequence
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, stc_pkg::OFS_ADDR, 32'h0);
		cmp_val("addr reset", stc_pkg::RST_ADDR, rd);
		apb(1'b0, 8'h20, 32'h0);
		cmp_val("unmapped err", 32'h1, {31'h0, rd_err});
		// a command met while the clock enable is low must leave no trace
		ce <= 1'b0;
		u_stc_interrogator.send(8'h55, 8'h01, 32'h0, 16'h0001);
		#1;
		cmp_val("reply while frozen", 32'h0, {31'h0, rv});
		ce <= 1'b1;
		cmd(8'h55, 8'h01, 32'h0, 1'b0, stc_pkg::ERR_OTHER);
		busy <= 1'b1;
		cmd(stc_pkg::CMD_SET_PW, 8'h01, 32'h1, 1'b0, stc_pkg::ERR_EE_BUSY);
		busy <= 1'b0;
		rtc <= 1'b1;
		cmd(stc_pkg::CMD_SET_LOG, 8'h00, 32'h0, 1'b0, stc_pkg::ERR_NOT_ALLOWED);
		rtc <= 1'b0;
		cmd(stc_pkg::CMD_SET_PW, 8'hfc, 32'h5, 1'b0, stc_pkg::ERR_OTHER);
		seed = lfsr(seed);
		pw = seed | 32'h1;
		cmd(stc_pkg::CMD_SET_PW, 8'hfd, pw, 1'b1, 8'h00);
		cmp_val("ee addr", {16'h0, stc_pkg::RST_ADDR[15:0]}, {16'h0, eaddr});
		cmp_val("ee data", pw, edata);
		apb(1'b0, stc_pkg::OFS_PW_SYS, 32'h0);
		cmp_val("sys password", pw, rd);
		apb(1'b0, stc_pkg::OFS_STATUS, 32'h0);
		cmp_val("status", 32'hc4, {24'h0, rd[7:0]});
		cmd(stc_pkg::CMD_SET_PW, 8'h01, 32'h7, 1'b0, stc_pkg::ERR_PASSWORD);
		cmd(stc_pkg::CMD_SET_LOG, 8'h00, 32'h0, 1'b0, stc_pkg::ERR_PASSWORD);
		apb(1'b1, stc_pkg::OFS_CTRL, 32'h4);
		cmd(stc_pkg::CMD_SET_PW, 8'h03, 32'h9, 1'b0, stc_pkg::ERR_LOCKED);
		apb(1'b1, stc_pkg::OFS_CTRL, 32'h0);
		u_stc_interrogator.open_area(stc_pkg::LVL_SYS, pw);
		cmd(stc_pkg::CMD_SET_PW, 8'h02, pw ^ 32'h3c, 1'b1, 8'h00);
		// random log modes, the first with the shortest interval
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			m = {8'h00, seed[23:17], 1'b0, (i == 0) ? 16'h0000 : seed[15:0]};
			cmd(stc_pkg::CMD_SET_LOG, 8'h00, m, 1'b1, 8'h00);
			cmp_val("log mode", {8'h00, m[23:1], 1'b0}, {8'h00, lmode});
			cmp_val("period", {16'h0, 1'b0, m[15:1]} + 32'h1, {16'h0, period});
			cmp_val("log ee addr", {16'h0, stc_pkg::RST_ADDR[31:16]}, {16'h0, eaddr});
			cmp_val("log ee data", {8'h00, m[23:1], 1'b0}, edata);
		end
		passive <= 1'b1;
		sup_low <= 1'b1;
		cmd(stc_pkg::CMD_SET_LOG, 8'h00, 32'h0001_0000, 1'b0, stc_pkg::ERR_BATT_MEAS);
		cmd(stc_pkg::CMD_SET_PW, 8'h03, 32'h11, 1'b0, stc_pkg::ERR_POWER);
		passive <= 1'b0;
		sup_low <= 1'b0;
		apb(1'b1, stc_pkg::OFS_ADDR, {16'h0010, stc_pkg::EE_WORDS - 16'h1});
		cmd(stc_pkg::CMD_SET_PW, 8'h01, pw, 1'b0, stc_pkg::ERR_OVERRUN);
		apb(1'b1, stc_pkg::OFS_ADDR, stc_pkg::RST_ADDR);
		// pin needs two synchroniser stages before the check can see it
		bpin <= 1'b1;
		repeat (3) @(posedge clk);
		cmd(stc_pkg::CMD_SET_LOG, 8'h00, 32'h0002_0004, 1'b1, 8'h00);
		cmp_val("low battery", 32'h1, {31'h0, lowb});
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		watch(6, seen, seen_b);
		cmp_val("store while low", 32'h0, {31'h0, seen});
		cmp_val("low battery held", 32'h1, {31'h0, lowb});
		bpin <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, stc_pkg::OFS_STATUS, 32'h1);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		watch(6, seen, seen_b);
		cmp_val("store when good", 32'h1, {31'h0, seen});
		cmp_val("batt store off", 32'h0, {31'h0, seen_b});
		fl <= 1'b1;
		@(posedge clk);
		fl <= 1'b0;
		cmd(stc_pkg::CMD_SET_PW, 8'h02, 32'h21, 1'b0, stc_pkg::ERR_PASSWORD);
		tally_and_finish();
	end
endmodule
`default_nettype wire
